// file: common/dcsm_pkg.sv
package dcsm_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [7:0] DCSM_CTRL_OFS = 8'h00;
	localparam logic [7:0] DCSM_SEL_A_OFS = 8'h04;
	localparam logic [7:0] DCSM_SEL_B_OFS = 8'h08;
	localparam logic [7:0] DCSM_SEL_C_OFS = 8'h0C;
	localparam logic [7:0] DCSM_STATUS_OFS = 8'h10;
	// control: write one to clear a latched fault
	localparam int DCSM_CTRL_CLR_BIT = 0;
	// status field positions
	localparam int DCSM_ST_DRIVE_BIT = 0;
	localparam int DCSM_ST_STOP_BIT = 1;
	localparam int DCSM_ST_HEALTHY_BIT = 2;
	localparam int DCSM_ST_FAULT_BIT = 3;
	localparam int DCSM_ST_CH1_BIT = 4;
	localparam int DCSM_ST_CH2_BIT = 5;
	localparam int DCSM_ST_POWER_BIT = 6;
	// ------------------------------------------------------------
	// output selection codes
	// ------------------------------------------------------------
	localparam logic [7:0] DCSM_CODE_RUNNING = 8'h00;
	localparam logic [7:0] DCSM_CODE_STOP_POS = 8'h50;
	localparam logic [7:0] DCSM_CODE_STOP_NEG = 8'hB4;
	localparam logic [7:0] DCSM_CODE_HEALTHY_POS = 8'h51;
	localparam logic [7:0] DCSM_CODE_HEALTHY_NEG = 8'hB5;
	// values after reset
	localparam logic [7:0] DCSM_SEL_A_RST = DCSM_CODE_RUNNING;
	localparam logic [7:0] DCSM_SEL_B_RST = DCSM_CODE_RUNNING;
	localparam logic [7:0] DCSM_SEL_C_RST = DCSM_CODE_STOP_POS;
	// cycles from the access phase start to pready
	localparam int DCSM_APB_WAIT_CYC = 1;
	// ------------------------------------------------------------
	// indication bundle
	// ------------------------------------------------------------
	typedef struct packed {
		logic fault;
		logic healthy;
		logic stop_state;
		logic drive_en;
	} dcsm_ind_t;
endpackage : dcsm_pkg

// file: rtl/dcsm_top.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module dcsm_top (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic stop_channel_one_in,
	input wire logic stop_channel_two_in,
	input wire logic power_on_in,
	input wire logic running_in,
	input wire logic internal_fault_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic drive_enable_out,
	output logic stop_monitor_pin_out,
	output logic motion_active_pin_out,
	output logic aux_output_pin_out,
	output dcsm_pkg::dcsm_ind_t ind_out
);
	import dcsm_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;
	logic ch1_s;
	logic ch2_s;
	logic pwr_s;

	// two flops per pin; only the second stage is read
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end else begin
			pin_meta_r <= {power_on_in, stop_channel_two_in,
				stop_channel_one_in};
			pin_sync_r <= pin_meta_r;
		end
	end

	// high means channel shorted to its common
	assign ch1_s = pin_sync_r[0];
	assign ch2_s = pin_sync_r[1];
	assign pwr_s = pin_sync_r[2];

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic [7:0] sel_a_r;
	logic [7:0] sel_b_r;
	logic [7:0] sel_c_r;
	logic ready_r;
	logic [31:0] rdata_r;
	logic err_r;
	logic acc;
	logic wr_done;
	logic clr_req;
	logic mapped;
	logic [31:0] rd_nxt;

	assign acc = psel_in && penable_in;
	assign wr_done = acc && ready_r && pwrite_in;
	assign clr_req = wr_done && (paddr_in == DCSM_CTRL_OFS)
		&& pwdata_in[DCSM_CTRL_CLR_BIT];

	// read mux and address decode
	always_comb begin
		rd_nxt = 32'h0;
		mapped = 1'b1;
		case (paddr_in)
			DCSM_CTRL_OFS: rd_nxt = 32'h0;
			DCSM_SEL_A_OFS: rd_nxt = {24'h0, sel_a_r};
			DCSM_SEL_B_OFS: rd_nxt = {24'h0, sel_b_r};
			DCSM_SEL_C_OFS: rd_nxt = {24'h0, sel_c_r};
			DCSM_STATUS_OFS: begin
				rd_nxt[DCSM_ST_DRIVE_BIT] = ind_out.drive_en;
				rd_nxt[DCSM_ST_STOP_BIT] = ind_out.stop_state;
				rd_nxt[DCSM_ST_HEALTHY_BIT] = ind_out.healthy;
				rd_nxt[DCSM_ST_FAULT_BIT] = ind_out.fault;
				rd_nxt[DCSM_ST_CH1_BIT] = ch1_s;
				rd_nxt[DCSM_ST_CH2_BIT] = ch2_s;
				rd_nxt[DCSM_ST_POWER_BIT] = pwr_s;
			end
			default: mapped = 1'b0;
		endcase
	end

	// one wait state, answer flopped
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ready_r <= 1'b0;
			rdata_r <= 32'h0;
			err_r <= 1'b0;
		end else if (acc && !ready_r) begin
			ready_r <= 1'b1;
			rdata_r <= pwrite_in ? 32'h0 : rd_nxt;
			err_r <= !mapped;
		end else begin
			ready_r <= 1'b0;
			rdata_r <= 32'h0;
			err_r <= 1'b0;
		end
	end

	// output selection settings
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sel_a_r <= DCSM_SEL_A_RST;
			sel_b_r <= DCSM_SEL_B_RST;
			sel_c_r <= DCSM_SEL_C_RST;
		end else if (wr_done) begin
			if (paddr_in == DCSM_SEL_A_OFS)
				sel_a_r <= pwdata_in[7:0];
			if (paddr_in == DCSM_SEL_B_OFS)
				sel_b_r <= pwdata_in[7:0];
			if (paddr_in == DCSM_SEL_C_OFS)
				sel_c_r <= pwdata_in[7:0];
		end
	end

	assign prdata_out = rdata_r;
	assign pready_out = ready_r;
	assign pslverr_out = err_r;

	// ------------------------------------------------------------
	// stop supervision
	// ------------------------------------------------------------
	logic fault_r;
	logic fault_set;
	dcsm_ind_t ind_nxt;

	// with power on, one channel open and one shorted is a mismatch fault
	assign fault_set = (pwr_s && (ch1_s != ch2_s)) || internal_fault_in;

	// latched fault; set wins over a clear in the same cycle
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			fault_r <= 1'b0;
		else if (fault_set)
			fault_r <= 1'b1;
		else if (clr_req)
			fault_r <= 1'b0;
	end

	// state table evaluation
	always_comb begin
		ind_nxt.fault = fault_r || fault_set;
		// open channel or no power forces shutoff
		ind_nxt.drive_en = pwr_s && ch1_s && ch2_s
			&& !ind_nxt.fault;
		ind_nxt.stop_state = pwr_s && !ch1_s && !ch2_s
			&& !ind_nxt.fault;
		ind_nxt.healthy = pwr_s && !ind_nxt.fault;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			ind_out <= '0;
		else
			ind_out <= ind_nxt;
	end

	// ------------------------------------------------------------
	// open collector routing
	// ------------------------------------------------------------
	// one means transistor conducts
	function automatic logic route_pin(input logic [7:0] code,
		input dcsm_ind_t ind, input logic run);
		case (code)
			DCSM_CODE_RUNNING: route_pin = run;
			DCSM_CODE_STOP_POS: route_pin = ind.stop_state;
			DCSM_CODE_STOP_NEG: route_pin = !ind.stop_state;
			DCSM_CODE_HEALTHY_POS: route_pin = ind.healthy;
			DCSM_CODE_HEALTHY_NEG: route_pin = !ind.healthy;
			default: route_pin = 1'b0;
		endcase
	endfunction : route_pin

	// running status only counts while the drive is enabled
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			drive_enable_out <= 1'b0;
			motion_active_pin_out <= 1'b0;
			aux_output_pin_out <= 1'b0;
			stop_monitor_pin_out <= 1'b0;
		end else begin
			drive_enable_out <= ind_nxt.drive_en;
			motion_active_pin_out <= route_pin(sel_a_r, ind_nxt,
				running_in && ind_nxt.drive_en);
			aux_output_pin_out <= route_pin(sel_b_r, ind_nxt,
				running_in && ind_nxt.drive_en);
			stop_monitor_pin_out <= route_pin(sel_c_r, ind_nxt,
				running_in && ind_nxt.drive_en);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_open_shuts_off: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) (!ch1_s || !ch2_s) |=> !drive_enable_out)
		else $error("drive enabled with a channel open");

	a_drive_enable_cond: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		(pwr_s && ch1_s && ch2_s && !fault_r && !internal_fault_in)
		|=> drive_enable_out && !ind_out.stop_state && ind_out.healthy)
		else $error("drive not enabled in run state");

	a_stop_ind_excl: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		ind_out.stop_state |-> !ind_out.drive_en && !ind_out.fault)
		else $error("stop indicator with drive or fault");

	a_healthy_fault: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) $rose(fault_r) |-> !ind_out.healthy)
		else $error("healthy while fault latched");

	a_mismatch_fault: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) (pwr_s && ch1_s && !ch2_s)
		|=> fault_r ##1 (!ind_out.stop_state && !ind_out.healthy))
		else $error("channel mismatch not flagged");

	a_power_off_dark: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) !pwr_s |=> ind_out == '0 || ind_out.fault)
		else $error("indication with power off");

	a_stop_pin_route: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) (sel_c_r == DCSM_CODE_STOP_POS)
		##1 (sel_c_r == DCSM_CODE_STOP_POS)
		|-> stop_monitor_pin_out == ind_out.stop_state)
		else $error("stop pin not following indicator");

	a_healthy_neg: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) (sel_b_r == DCSM_CODE_HEALTHY_NEG)
		##1 (sel_b_r == DCSM_CODE_HEALTHY_NEG)
		|-> aux_output_pin_out == !ind_out.healthy)
		else $error("negative healthy routing wrong");

	a_restart_block: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) (sel_a_r == DCSM_CODE_HEALTHY_POS
		&& fault_set) |=> !motion_active_pin_out)
		else $error("motion pin on during fault");

	// only once two edges out of reset, so flushed stages are not compared
	a_sync_depth: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) ($past(rst_n_in) && $past(rst_n_in, 2))
		|-> (ch1_s == $past(stop_channel_one_in, 2)))
		else $error("channel one sync depth wrong");
endmodule : dcsm_top

// file: testbench/dcsm_relay_model.sv
`timescale 1ns/1ps
// safety relay: opens channels on command
module dcsm_relay_model (
	input wire logic mclk_in,
	input wire logic open_in,
	input wire logic skew_in,
	input wire logic feedback_in,
	output logic ch_one_out,
	output logic ch_two_out,
	output logic restart_ok_out
);
	// channel contacts, skew opens only channel one
	always_ff @(posedge mclk_in) begin
		ch_one_out <= !(open_in | skew_in);
		ch_two_out <= !open_in;
	end
	// restart allowed only while feedback conducts
	assign restart_ok_out = feedback_in;
endmodule : dcsm_relay_model

// file: testbench/tb_dual_channel_stop_monitor.sv
`timescale 1ns/1ps
module tb_dual_channel_stop_monitor;
	import dcsm_pkg::*;
	logic clk = 0, rst_n = 0, pw = 0, run = 0, ifl = 0;
	logic psel = 0, pen = 0, pwr = 0;
	logic [7:0] pa = 0;
	logic [31:0] pwd = 0, prd, rd;
	logic rdy, err, er, drv, sp, mp, ap, c1, c2, rok;
	logic op = 0, sk = 0, rop = 0;
	dcsm_ind_t ind;
	logic [7:0] sa, sb, sc;
	// last entry is an unused code, expected to leave its pin off
	logic [7:0] codes [6] = '{DCSM_CODE_RUNNING, DCSM_CODE_STOP_POS,
		DCSM_CODE_STOP_NEG, DCSM_CODE_HEALTHY_POS, DCSM_CODE_HEALTHY_NEG,
		8'h07};
	int error_cnt = 0, tests_run = 0, cyc = 0;
	always #5 clk = ~clk;
	dcsm_top u_dcsm_top (.mclk_in(clk), .rst_n_in(rst_n),
		.stop_channel_one_in(c1), .stop_channel_two_in(c2),
		.power_on_in(pw), .running_in(run), .internal_fault_in(ifl),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
		.pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
		.pslverr_out(err), .drive_enable_out(drv),
		.stop_monitor_pin_out(sp), .motion_active_pin_out(mp),
		.aux_output_pin_out(ap), .ind_out(ind));
	dcsm_relay_model u_dcsm_relay_model (.mclk_in(clk), .open_in(op),
		.skew_in(sk), .feedback_in(mp), .ch_one_out(c1),
		.ch_two_out(c2), .restart_ok_out(rok));
	// ----------------------------------------
	// expectations and compares
	// ----------------------------------------
	function automatic dcsm_ind_t exp_ind(logic p, logic o, logic f);
		dcsm_ind_t e;
		e = '0;
		e.fault = f;
		if (p && !f) begin
			e.healthy = 1'b1;
			e.stop_state = o;
			e.drive_en = !o;
		end
		return e;
	endfunction : exp_ind
	function automatic logic exp_pin(logic [7:0] c, dcsm_ind_t i, logic r);
		case (c)
			DCSM_CODE_RUNNING: return r & i.drive_en;
			DCSM_CODE_STOP_POS: return i.stop_state;
			DCSM_CODE_STOP_NEG: return !i.stop_state;
			DCSM_CODE_HEALTHY_POS: return i.healthy;
			DCSM_CODE_HEALTHY_NEG: return !i.healthy;
			default: return 1'b0;
		endcase
	endfunction : exp_pin
	// status word from expected indications and pin levels
	function automatic logic [31:0] exp_st(dcsm_ind_t i, logic p, logic a,
		logic b);
		logic [31:0] s;
		s = '0;
		s[DCSM_ST_DRIVE_BIT] = i.drive_en;
		s[DCSM_ST_STOP_BIT] = i.stop_state;
		s[DCSM_ST_HEALTHY_BIT] = i.healthy;
		s[DCSM_ST_FAULT_BIT] = i.fault;
		s[DCSM_ST_CH1_BIT] = a;
		s[DCSM_ST_CH2_BIT] = b;
		s[DCSM_ST_POWER_BIT] = p;
		return s;
	endfunction : exp_st
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
		@(posedge clk);
		pen <= 1;
		// wait for pready; only the hang guard ends a stuck wait
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		rd = prd;
		er = err;
		psel <= 0;
		pen <= 0;
	endtask : apb
	task automatic drive(logic p, logic o, logic s);
		@(posedge clk);
		pw <= p; op <= o; sk <= s; run <= $urandom_range(1);
		repeat (5) @(posedge clk);
	endtask : drive
	task automatic check_all(dcsm_ind_t e);
		chk("ind", e, ind);
		chk("drive", e.drive_en, drv);
		chk("stop pin", exp_pin(sc, e, run), sp);
		chk("motion pin", exp_pin(sa, e, run), mp);
		chk("aux pin", exp_pin(sb, e, run), ap);
	endtask : check_all
	task automatic summarize;
		$display("errors %0d, checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	// main sequence
	initial begin
		void'($urandom(32'h11e5));
		repeat (20) @(posedge clk);
		rst_n <= 1;
		sa = DCSM_SEL_A_RST; sb = DCSM_SEL_B_RST; sc = DCSM_SEL_C_RST;
		apb(0, DCSM_SEL_A_OFS, 0); chk("sel a", sa, rd);
		apb(0, DCSM_SEL_C_OFS, 0); chk("sel c", sc, rd);
		apb(0, 8'h3C, 0); chk("slverr", 1, er);
		drive(1, 0, 0); check_all(exp_ind(1, 0, 0));
		apb(0, DCSM_STATUS_OFS, 0);
		chk("status", exp_st(exp_ind(1, 0, 0), 1, 1, 1), rd);
		drive(1, 1, 0); check_all(exp_ind(1, 1, 0));
		for (int i = 0; i < 16; i++) begin
			sa = codes[$urandom_range(5)];
			sb = codes[$urandom_range(5)];
			sc = codes[$urandom_range(5)];
			apb(1, DCSM_SEL_A_OFS, {24'h0, sa});
			apb(1, DCSM_SEL_B_OFS, {24'h0, sb});
			apb(1, DCSM_SEL_C_OFS, {24'h0, sc});
			rop = $urandom_range(1);
			drive(1, rop, 0); check_all(exp_ind(1, rop, 0));
		end
		sa = DCSM_CODE_HEALTHY_POS;
		apb(1, DCSM_SEL_A_OFS, {24'h0, sa});
		drive(1, 0, 1); check_all(exp_ind(1, 0, 1));
		chk("restart ok", 0, rok);
		apb(0, DCSM_STATUS_OFS, 0);
		chk("status", exp_st(exp_ind(1, 0, 1), 1, 0, 1), rd);
		drive(1, 0, 0); check_all(exp_ind(1, 0, 1));
		apb(1, DCSM_CTRL_OFS, 1);
		repeat (4) @(posedge clk);
		check_all(exp_ind(1, 0, 0));
		// one-cycle pulse of the other fault source latches a fault
		@(posedge clk);
		ifl <= 1;
		@(posedge clk);
		ifl <= 0;
		repeat (4) @(posedge clk);
		check_all(exp_ind(1, 0, 1));
		apb(1, DCSM_CTRL_OFS, 1);
		repeat (4) @(posedge clk);
		check_all(exp_ind(1, 0, 0));
		drive(0, 0, 0); check_all(exp_ind(0, 0, 0));
		summarize();
	end
endmodule : tb_dual_channel_stop_monitor
